// [core/vsi_video_input_sync.sv]
// video input synchroniser: slave sync and embedded timing code front end
//
// Summary of operation
// RULE_01 - control bit picks slave sync (0) or embedded timing codes (1)
// RULE_02 - embedded mode takes all timing from data, ignores sync pins
// RULE_03 - embedded mode refused while square pixel rate is selected
// RULE_04 - falling pixel clock edge samples when invert pin or edge bit is 1
// RULE_05 - with both at 0 the rising pixel clock edge samples bus and syncs
// RULE_06 - sync pins are examined on the same edge that captures data
// RULE_07 - hsync low sample is position 0; NTSC first Cb at 244 or 236
// RULE_08 - PAL first Cb word at 264 standard or 310 square pixel
// RULE_09 - vsync fall in window around hsync low marks odd field line 4
// RULE_10 - PAL controller drops vsync in that window on line 1
// RULE_11 - vertical resync only on odd field, other vsync falls ignored
// RULE_12 - missing sync: free-run on line timing learned from last sync
// RULE_13 - NTSC controller keeps vsync low about three lines
// RULE_14 - PAL controller keeps vsync low about two to three lines
// RULE_15 - controller drives black or non-reserved codes outside active video
// RULE_16 - PAL slave mode drops data of lines 23 and 623
// RULE_17 - byte after FF 00 00 is a timing code; sync to EAV codes
// RULE_18 - timing code bits: 7 one, 6 F, 5 V, 4 H, 3..0 protection
// RULE_19 - F low field 1, V high blanking, H high EAV, H low SAV
// RULE_20 - protection nibble follows the fixed F V H table
// RULE_21 - EAV starts at luma 720, line ends at 857 or 863
// RULE_22 - embedded mode frame sync when EAV field flag goes 1 to 0
// RULE_23 - controller supplies 27 MHz or square pixel clock per rate bit
`timescale 1ns/10ps
`default_nettype none
module vsi_video_input_sync
  import vsi_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pixel bus pins
  input wire logic pixel_clock_in,
  input wire logic sample_edge_invert_pin,
  input wire logic horizontal_sync_in,
  input wire logic vertical_sync_in,
  input wire logic [7:0] pixel_data_in,
  // axi4-lite write channels
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // captured video stream
  output logic [7:0] video_data_out,
  output logic video_valid_out,
  output logic first_blue_chroma_word,
  output logic line_start_out,
  output logic field_out,
  output logic [9:0] line_number_out
);

  // protection nibble for a flag triple
  function automatic logic [3:0] trs_protect(input logic [2:0] fvh);
    return {fvh[1] ^ fvh[0], fvh[2] ^ fvh[0], fvh[2] ^ fvh[1], ^fvh};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin sampling

  logic [PIN_W-1:0] pins_stable;
  logic pclk_prev_reg;
  logic sample_edge_select;
  logic square_pixel_rate_select;
  logic embedded_sync_select;
  logic pal_select;
  logic emb_mode;
  logic invert_edge;
  logic sample_now;
  logic pclk_s;
  logic hs_s;
  logic vs_s;
  logic [7:0] data_s;

  vsi_pin_sync #(
    .W(PIN_W)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins_in({pixel_clock_in, sample_edge_invert_pin, horizontal_sync_in,
              vertical_sync_in, pixel_data_in}),
    .pins_stable(pins_stable)
  );

  assign pclk_s = pins_stable[11];
  assign hs_s = pins_stable[9];
  assign vs_s = pins_stable[8];
  assign data_s = pins_stable[7:0];

  // select sampling edge of the pixel clock
  assign invert_edge = pins_stable[10] | sample_edge_select;
  assign sample_now = invert_edge ? (pclk_prev_reg & ~pclk_s)  // RULE_04
                                  : (~pclk_prev_reg & pclk_s);  // RULE_05

  // embedded decoding only at the standard rate
  assign emb_mode = embedded_sync_select & ~square_pixel_rate_select;  // RULE_01 RULE_03

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pclk_prev_reg <= 1'b0;
    end else begin
      pclk_prev_reg <= pclk_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sampled sync edges and vsync window

  logic hs_prev_reg;
  logic vs_prev_reg;
  logic hs_fall;
  logic hs_rise;
  logic vs_fall;
  logic [3:0] vs_age_reg;
  logic cand_reg;
  logic fell_low_reg;
  logic odd_hit;

  // syncs judged only on the data sampling edge, ignored in embedded mode
  assign hs_fall = sample_now & ~emb_mode & hs_prev_reg & ~hs_s;  // RULE_06 RULE_02
  assign hs_rise = sample_now & ~emb_mode & ~hs_prev_reg & hs_s;
  assign vs_fall = sample_now & ~emb_mode & vs_prev_reg & ~vs_s;

  // vsync fell up to 3 before hsync fall, or at least 3 before its rise
  assign odd_hit = hs_rise & (cand_reg | (fell_low_reg & (vs_age_reg >= VS_WINDOW)));  // RULE_09

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_prev_reg <= 1'b1;
      vs_prev_reg <= 1'b1;
      vs_age_reg <= VS_AGE_MAX;
      cand_reg <= 1'b0;
      fell_low_reg <= 1'b0;
    end else if (sample_now) begin
      hs_prev_reg <= hs_s;
      vs_prev_reg <= vs_s;
      if (vs_fall) begin
        vs_age_reg <= 4'h1;
      end else if (vs_age_reg != VS_AGE_MAX) begin
        vs_age_reg <= vs_age_reg + 4'h1;
      end
      if (hs_fall) begin
        cand_reg <= vs_fall | (vs_age_reg <= VS_WINDOW);
        fell_low_reg <= 1'b0;
      end else if (hs_rise) begin
        cand_reg <= 1'b0;
        fell_low_reg <= 1'b0;
      end else if (vs_fall && !hs_s) begin
        fell_low_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // timing reference code decoding

  logic [23:0] pre_reg;
  logic trs_seen;
  logic trs_ok;
  logic eav_ok;
  logic sav_ok;
  logic f_last_reg;
  logic vblank_reg;
  logic prot_err_reg;
  logic prot_clr;
  logic sav_arm_reg;

  // code byte after the preamble: fixed one and protection
  assign trs_seen = sample_now & emb_mode & (pre_reg == TRS_PREAMBLE);  // RULE_17
  assign trs_ok = data_s[TRS_ONE_BIT]
                  & (data_s[3:0] == trs_protect(data_s[TRS_F_BIT:TRS_H_BIT]));  // RULE_18 RULE_20
  assign eav_ok = trs_seen & trs_ok & data_s[TRS_H_BIT];  // RULE_19
  assign sav_ok = trs_seen & trs_ok & ~data_s[TRS_H_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg <= '0;
      f_last_reg <= 1'b0;
      vblank_reg <= 1'b0;
      sav_arm_reg <= 1'b0;
    end else if (sample_now) begin
      pre_reg <= {pre_reg[15:0], data_s};
      sav_arm_reg <= sav_ok & ~data_s[TRS_V_BIT];  // RULE_19
      if (eav_ok) begin
        f_last_reg <= data_s[TRS_F_BIT];
        vblank_reg <= data_s[TRS_V_BIT];
      end
    end
  end

  // sticky protection error, a new error wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prot_err_reg <= 1'b0;
    end else if (trs_seen && !trs_ok) begin
      prot_err_reg <= 1'b1;
    end else if (prot_clr) begin
      prot_err_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // line timing, line and field counting

  logic [11:0] h_cnt_reg;
  logic [11:0] line_len_reg;
  logic h_seen_reg;
  logic wrap_seen_reg;
  logic h_wrap;
  logic new_line;
  logic [9:0] line_reg;
  logic [9:0] frame_lines;
  logic [9:0] odd_line;
  logic [9:0] field2_line;
  logic [9:0] line_inc;
  logic field_reg;
  vsi_lock_t lock_reg;
  logic vresync;

  assign frame_lines = pal_select ? FRAME_LINES_PAL : FRAME_LINES_NTSC;
  assign odd_line = pal_select ? ODD_LINE_PAL : ODD_LINE_NTSC;
  assign field2_line = pal_select ? FIELD2_LINE_PAL : FIELD2_LINE_NTSC;
  assign line_inc = (line_reg >= frame_lines) ? LINE_ONE : line_reg + 10'h001;

  // free-run wrap when hsync does not come
  assign h_wrap = sample_now & ~emb_mode & ~hs_fall & (h_cnt_reg >= line_len_reg - 12'h001);  // RULE_12
  // an hsync soon after a free-run wrap does not count twice
  assign new_line = h_wrap | (hs_fall & (h_cnt_reg > (line_len_reg >> 1))) | eav_ok;
  // odd field accepted while hunting or in the first field only
  assign vresync = (odd_hit & ((lock_reg == LOCK_HUNT) | ~field_reg))  // RULE_11
                   | (eav_ok & f_last_reg & ~data_s[TRS_F_BIT]);  // RULE_22

  // pixel position counter and learned line length
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_cnt_reg <= '0;
      line_len_reg <= LINE_LEN_RESET;
      h_seen_reg <= 1'b0;
      wrap_seen_reg <= 1'b0;
    end else if (sample_now) begin
      if (hs_fall || h_wrap || eav_ok) begin
        h_cnt_reg <= '0;  // RULE_07
        wrap_seen_reg <= h_wrap;
      end else begin
        h_cnt_reg <= h_cnt_reg + 12'h001;
      end
      if (hs_fall) begin
        h_seen_reg <= 1'b1;
        if (h_seen_reg && !wrap_seen_reg) begin
          line_len_reg <= h_cnt_reg + 12'h001;  // RULE_12
        end
      end
    end
  end

  // line number, field and lock tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_reg <= LINE_ONE;
      field_reg <= 1'b0;
      lock_reg <= LOCK_HUNT;
    end else if (sample_now) begin
      if (vresync) begin
        line_reg <= odd_line;
        field_reg <= 1'b0;
        lock_reg <= LOCK_HELD;
      end else if (new_line) begin
        line_reg <= line_inc;
        if (eav_ok) begin
          field_reg <= data_s[TRS_F_BIT];  // RULE_19
        end else begin
          field_reg <= (line_inc >= field2_line) || (line_inc < odd_line);
        end
      end
      if (!emb_mode && !h_seen_reg) begin
        lock_reg <= LOCK_HUNT;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // active video capture

  logic [11:0] cb0_pos;
  logic [11:0] act_cnt_reg;
  logic line_visible;
  logic act_start;

  // first chroma word per standard and rate
  always_comb begin
    case ({pal_select, square_pixel_rate_select})
      2'b00: cb0_pos = CB0_NTSC_STD;  // RULE_07
      2'b01: cb0_pos = CB0_NTSC_SQ;
      2'b10: cb0_pos = CB0_PAL_STD;  // RULE_08
      2'b11: cb0_pos = CB0_PAL_SQ;
      default: cb0_pos = CB0_NTSC_STD;
    endcase
  end

  // PAL slave lines 23 and 623 never reach the output
  assign line_visible = ~(pal_select & ((line_reg == HIDDEN_LINE_A_PAL)
                                        | (line_reg == HIDDEN_LINE_B_PAL)));  // RULE_16
  assign act_start = emb_mode ? sav_arm_reg
                              : (~hs_fall & ~h_wrap & line_visible
                                 & (h_cnt_reg + 12'h001 == cb0_pos));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_cnt_reg <= '0;
      video_data_out <= 8'h00;
      video_valid_out <= 1'b0;
      first_blue_chroma_word <= 1'b0;
    end else begin
      video_valid_out <= 1'b0;
      first_blue_chroma_word <= 1'b0;
      if (sample_now) begin
        if (act_start) begin
          act_cnt_reg <= ACTIVE_WORDS - 12'h001;
          video_data_out <= data_s;
          video_valid_out <= 1'b1;
          first_blue_chroma_word <= 1'b1;
        end else if (act_cnt_reg != 12'h000) begin
          act_cnt_reg <= act_cnt_reg - 12'h001;
          video_data_out <= data_s;
          video_valid_out <= 1'b1;
        end
      end
    end
  end

  // line start pulse and registered line state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_start_out <= 1'b0;
      field_out <= 1'b0;
      line_number_out <= LINE_ONE;
    end else begin
      line_start_out <= sample_now & (new_line | vresync);
      field_out <= field_reg;
      line_number_out <= line_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite register slave

  logic [3:0] ctrl_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [AXI_ADDR_W-1:0] aw_addr_reg;
  logic [AXI_DATA_W-1:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic [AXI_DATA_W-1:0] status_word;
  logic [AXI_DATA_W-1:0] pos_word;

  assign embedded_sync_select = ctrl_reg[CTRL_EMBEDDED_BIT];
  assign sample_edge_select = ctrl_reg[CTRL_EDGE_BIT];
  assign square_pixel_rate_select = ctrl_reg[CTRL_SQUARE_BIT];
  assign pal_select = ctrl_reg[CTRL_PAL_BIT];
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign prot_clr = do_write & (aw_addr_reg == REG_STATUS) & w_strb_reg[0]
                    & w_data_reg[STAT_PROT_ERR_BIT];

  // status and position read words
  always_comb begin
    status_word = '0;
    status_word[STAT_LOCK_BIT] = (lock_reg == LOCK_HELD);
    status_word[STAT_FIELD_BIT] = field_reg;
    status_word[STAT_VBLANK_BIT] = vblank_reg;
    status_word[STAT_REFUSED_BIT] = embedded_sync_select & square_pixel_rate_select;  // RULE_03
    status_word[STAT_PROT_ERR_BIT] = prot_err_reg;
    status_word[STAT_LINE_LSB +: 10] = line_reg;
    pos_word = '0;
    pos_word[11:0] = h_cnt_reg;
    pos_word[POS_LEN_LSB +: 12] = line_len_reg;
  end

  // write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_reg & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_held_reg & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // control register update and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OKAY;
        if (aw_addr_reg == REG_CTRL) begin
          if (w_strb_reg[0]) begin
            ctrl_reg <= w_data_reg[3:0];
          end
        end else if (aw_addr_reg != REG_STATUS && aw_addr_reg != REG_POS) begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          REG_CTRL: s_axi_rdata <= {28'h000_0000, ctrl_reg};
          REG_STATUS: s_axi_rdata <= status_word;
          REG_POS: s_axi_rdata <= pos_word;
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [core/vsi_pkg.sv]
// constants and types shared by the video input synchroniser
package vsi_pkg;

  // register bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_POS = 8'h08;

  // control register fields and reset value
  localparam int CTRL_EMBEDDED_BIT = 0;
  localparam int CTRL_EDGE_BIT = 1;
  localparam int CTRL_SQUARE_BIT = 2;
  localparam int CTRL_PAL_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // status register fields
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_FIELD_BIT = 1;
  localparam int STAT_VBLANK_BIT = 2;
  localparam int STAT_REFUSED_BIT = 3;
  localparam int STAT_PROT_ERR_BIT = 4;
  localparam int STAT_LINE_LSB = 16;
  localparam int POS_LEN_LSB = 16;

  // sampled pins: clock, invert, hsync, vsync, data
  localparam int PIN_W = 12;

  // first chroma word position after hsync falls
  localparam logic [11:0] CB0_NTSC_STD = 12'h0f4;
  localparam logic [11:0] CB0_NTSC_SQ = 12'h0ec;
  localparam logic [11:0] CB0_PAL_STD = 12'h108;
  localparam logic [11:0] CB0_PAL_SQ = 12'h136;
  localparam logic [11:0] ACTIVE_WORDS = 12'h5a0;
  localparam logic [11:0] LINE_LEN_RESET = 12'h6b4;

  // odd field window and line numbering
  localparam logic [3:0] VS_WINDOW = 4'h3;
  localparam logic [3:0] VS_AGE_MAX = 4'hf;
  localparam logic [9:0] ODD_LINE_NTSC = 10'h004;
  localparam logic [9:0] ODD_LINE_PAL = 10'h001;
  localparam logic [9:0] FRAME_LINES_NTSC = 10'h20d;
  localparam logic [9:0] FRAME_LINES_PAL = 10'h271;
  localparam logic [9:0] FIELD2_LINE_NTSC = 10'h10a;
  localparam logic [9:0] FIELD2_LINE_PAL = 10'h139;
  localparam logic [9:0] HIDDEN_LINE_A_PAL = 10'h017;
  localparam logic [9:0] HIDDEN_LINE_B_PAL = 10'h26f;
  localparam logic [9:0] LINE_ONE = 10'h001;

  // timing reference code layout
  localparam logic [23:0] TRS_PREAMBLE = 24'hff_0000;
  localparam int TRS_ONE_BIT = 7;
  localparam int TRS_F_BIT = 6;
  localparam int TRS_V_BIT = 5;
  localparam int TRS_H_BIT = 4;

  // lock tracking states
  typedef enum logic [1:0] {
    LOCK_HUNT = 2'b01,
    LOCK_HELD = 2'b10
  } vsi_lock_t;

endpackage

// [core/vsi_pin_sync.sv]
// three-stage synchroniser with agreement filter for pixel bus pins
`timescale 1ns/10ps
`default_nettype none
module vsi_pin_sync
  import vsi_pkg::*;
#(
  parameter int W = PIN_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw pins and filtered result
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] pins_stable
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;
  logic [W-1:0] stage3_reg;

  // shift chain; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= pins_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // a bit changes once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_stable <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2_reg[i] == stage3_reg[i]) begin
          pins_stable[i] <= stage3_reg[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

// [testbench/vsi_chk.sv]
// port checker for the video input synchroniser
`timescale 1ns/10ps
`default_nettype none
module vsi_chk
  import vsi_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
  // video stream
  input wire logic video_valid_out,
  input wire logic first_blue_chroma_word,
  input wire logic line_start_out,
  input wire logic [9:0] line_number_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // handshake steps
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // register bus answers
  wr_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("late write response");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_resp_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("late read data");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ////////////////////////////////////////////////////////////////////////////////
  // video stream timing
  first_cb_a: assert property (first_blue_chroma_word |-> video_valid_out)
    else $error("marker without byte");
  one_sample_a: assert property (video_valid_out |=> !video_valid_out [*5])
    else $error("two bytes per edge");
  line_pulse_a: assert property (line_start_out |=> !line_start_out [*8])
    else $error("line starts too close");
  line_step_a: assert property ($changed(line_number_out) |-> line_start_out || $past(line_start_out))
    else $error("line moved without start");
  line_range_a: assert property (line_number_out inside {[LINE_ONE:FRAME_LINES_PAL]})
    else $error("line out of range");
endmodule
bind vsi_video_input_sync vsi_chk i_vsi_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .video_valid_out, .first_blue_chroma_word,
  .line_start_out, .line_number_out
);
`default_nettype wire

// [testbench/vsi_ctrl_model.sv]
// video controller model: pixel clock, syncs and byte stream
`timescale 1ns/10ps
`default_nettype none
module vsi_ctrl_model (
  // pixel bus toward the synchroniser
  output var logic pclk,
  output var logic hsync_n,
  output var logic vsync_n,
  output var logic [7:0] data
);
  // pixel clock, slower than a sixth of aclk
  initial begin
    pclk = 1'b0;
    forever #130 pclk = ~pclk;
  end
  initial begin
    hsync_n = 1'b1;
    vsync_n = 1'b1;
    data = 8'h10;
  end
  // one line; marker byte at the first chroma slot
  task automatic slave_line(input int cb0);
    for (int i = 0; i < 1760; i++) begin
      @(negedge pclk);
      hsync_n <= (i >= 128);
      vsync_n <= (i >= 1700);
      data <= (i == cb0) ? 8'hc1 : (i[0] ? 8'h10 : 8'h80);
    end
  endtask
  // preamble, code byte, black filler
  task automatic trs(input logic [2:0] fvh, input logic bad);
    logic [3:0] p;
    logic [7:0] seq [6];
    p = 4'(32'h1ca7_6bd0 >> {fvh, 2'b00});
    seq = '{8'hff, 8'h00, 8'h00, {1'b1, fvh, p ^ {3'h0, bad}}, 8'h80, 8'h10};
    foreach (seq[k]) begin
      @(negedge pclk);
      data <= seq[k];
    end
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the video input synchroniser
`timescale 1ns/10ps
`default_nettype none
module tb
  import vsi_pkg::*;
;
  logic aclk, aresetn, pclk, hsync_n, vsync_n;
  logic [7:0] pdata, video_data_out, cap;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata, d;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic video_valid_out, first_blue_chroma_word, line_start_out, field_out, fld;
  logic [9:0] line_number_out, ln;
  logic [11:0] cnt;
  int num_errors = 0;
  int num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // design, controller model, clock
  vsi_video_input_sync i_vsi_video_input_sync (
    .aclk, .aresetn, .pixel_clock_in(pclk), .sample_edge_invert_pin(1'b0),
    .horizontal_sync_in(hsync_n), .vertical_sync_in(vsync_n), .pixel_data_in(pdata),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .video_data_out, .video_valid_out,
    .first_blue_chroma_word, .line_start_out, .field_out, .line_number_out
  );
  vsi_ctrl_model i_model (.pclk, .hsync_n, .vsync_n, .data(pdata));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // first byte of a line and byte count
  always_ff @(posedge aclk) begin
    if (first_blue_chroma_word) begin
      cnt <= 12'h001;
      cap <= video_data_out;
      ln <= line_number_out;
      fld <= field_out;
    end else if (video_valid_out) begin
      cnt <= cnt + 12'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // comparison, verdict, bus cycles
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic give_up;
    num_errors++;
    report_and_stop();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      s_axi_bready <= (n >= 3) && !(s_axi_bvalid && s_axi_bready);
    end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
    r = s_axi_bresp;
    if (n >= 100) give_up();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      s_axi_rready <= (n >= 2) && !(s_axi_rvalid && s_axi_rready);
    end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 100) give_up();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic sc_regs;
    axi_rd(REG_CTRL, d, r);
    chk(d, 32'(CTRL_RESET));
    axi_rd(8'h0c, d, r);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    axi_wr(REG_CTRL, 32'h0000_000a, r);
    axi_rd(REG_CTRL, d, r);
    chk({r, d[29:0]}, {RESP_OKAY, 30'h0000_000a});
  endtask
  task automatic sc_slave(input logic [31:0] ctrl, input int cb0, input logic [9:0] odd);
    axi_wr(REG_CTRL, ctrl, r);
    i_model.slave_line(cb0);
    chk(32'(cnt), 32'(ACTIVE_WORDS));
    chk(32'(cap), 32'h0000_00c1);
    chk(32'({fld, ln}), 32'(odd));
  endtask
  task automatic sc_embedded;
    axi_wr(REG_CTRL, 32'h0000_0001, r);
    i_model.trs(3'h5, 1'b0);
    chk(32'(field_out), 32'h1);
    i_model.trs(3'h1, 1'b0);
    chk(32'({field_out, line_number_out}), 32'(ODD_LINE_NTSC));
    i_model.trs(3'h3, 1'b1);
    axi_rd(REG_STATUS, d, r);
    chk(32'(d[STAT_PROT_ERR_BIT]), 32'h1);
    axi_wr(REG_STATUS, 32'h0000_0010, r);
    axi_rd(REG_STATUS, d, r);
    chk(32'(d[STAT_PROT_ERR_BIT]), 32'h0);
    axi_wr(REG_CTRL, 32'h0000_0005, r);
    axi_rd(REG_STATUS, d, r);
    chk(32'(d[STAT_REFUSED_BIT]), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    sc_regs();
    sc_slave(32'h0000_0000, CB0_NTSC_STD, ODD_LINE_NTSC);
    sc_slave(32'h0000_0004, CB0_NTSC_SQ, ODD_LINE_NTSC);
    sc_slave(32'h0000_0008, CB0_PAL_STD, ODD_LINE_PAL);
    sc_slave(32'h0000_000c, CB0_PAL_SQ, ODD_LINE_PAL);
    sc_embedded();
    report_and_stop();
  end
endmodule
`default_nettype wire
